// ### rtl/cid_pkg.sv
// Constants and types for the configurable input dispatcher
package cid_pkg;

   localparam int NUM_IN      = 8;
   localparam int CLK_MHZ     = 250;
   localparam int DEB_TIME_US = 20;
   localparam int DEB_CYCLES  = DEB_TIME_US * CLK_MHZ;

   // Register byte offsets
   localparam logic [7:0] INCFG0_OFS   = 8'h00;
   localparam logic [7:0] CTRL_OFS     = 8'h20;
   localparam logic [7:0] LEVEL_OFS    = 8'h24;
   localparam logic [7:0] OUTSTAT_OFS  = 8'h28;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h2C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h30;

   // Field positions
   localparam int CTRL_VREG_BIT = 0;
   localparam int LEVEL_ACT_LSB = 8;
   localparam int IRQ_FAIL      = 0;
   localparam int IRQ_WARN      = 1;
   localparam int IRQ_START     = 2;
   localparam int IRQ_STOP      = 3;
   localparam int IRQ_CHG       = 4;
   localparam int IRQ_W         = 5;

   // Reset values
   localparam logic [7:0]       INCFG_RST = 8'h00;
   localparam logic             CTRL_RST  = 1'b0;
   localparam logic [IRQ_W-1:0] MASK_RST  = 5'h00;

   // Failure and warning bit positions
   localparam int FL_AIR = 0;
   localparam int FL_HYD = 1;
   localparam int FL_OIL = 2;
   localparam int FL_COOL = 3;
   localparam int FL_SUPPLY = 4;
   localparam int FL_AUX = 5;
   localparam int FL_CFG1 = 6;
   localparam int FL_CFG2 = 7;
   localparam int WN_AUX = 0;
   localparam int WN_CHG1 = 1;
   localparam int WN_CHG2 = 2;
   localparam int WN_FUEL = 3;
   localparam int WN_CFG1 = 4;
   localparam int WN_CFG2 = 5;

   typedef enum logic [4:0] {
      FN_NONE, FN_LOW_AIR, FN_LOW_HYD, FN_LOW_OIL, FN_SUPPLY_LOAD, FN_SILENCE,
      FN_LOW_COOL, FN_VSEL1, FN_VSEL2, FN_IDLE, FN_START_STOP, FN_AUX_FAIL,
      FN_AUX_WARN, FN_CHG1, FN_CHG2, FN_HI_FUEL, FN_CFG_WARN1, FN_CFG_WARN2,
      FN_CFG_FAIL1, FN_CFG_FAIL2
   } cid_func_e;

   typedef enum logic [1:0] {Q_GLOBAL, Q_CRANK, Q_RUN, Q_CRANK_RUN} cid_qual_e;

   typedef enum logic [2:0] {
      CS_OFF, CS_AUTO, CS_DELAY_START, CS_CRANKING, CS_CRANK_REST, CS_RUN,
      CS_FAILURE, CS_STOPPING
   } cid_ctl_e;

   typedef struct packed {
      logic      inv;
      cid_qual_e qual;
      cid_func_e func;
   } cid_incfg_s;

   typedef struct packed {
      logic [7:0] fail;
      logic [5:0] warn;
      logic [3:0] msg_show;
      logic       supply_lamp;
      logic       buzzer_mute;
      logic [1:0] volt_sel;
      logic       idle_show;
      logic       under_inhibit;
      logic       vreg_off;
      logic       start_req;
      logic       stop_req;
   } cid_out_s;

endpackage : cid_pkg

// ### rtl/cid_top.sv
// Configurable input dispatcher: debounced inputs mapped to controller functions
`timescale 1ns/1ns
module cid_top #(
   parameter int DEB_CYCLES = cid_pkg::DEB_CYCLES
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [7:0]        din_raw,
   input  wire cid_pkg::cid_ctl_e ctl_state,
   output cid_pkg::cid_out_s      fn_out,
   output logic                   irq
);

   localparam int N = cid_pkg::NUM_IN;
   localparam logic [15:0] DEB_M1 = 16'(DEB_CYCLES - 1);

   if (DEB_CYCLES < 2 || DEB_CYCLES > 65535) begin : g_chk
      $error("DEB_CYCLES must lie in 2..65535");
   end

   function automatic logic in_crank(input cid_pkg::cid_ctl_e s);
      in_crank = (s == cid_pkg::CS_DELAY_START) || (s == cid_pkg::CS_CRANKING) ||
                 (s == cid_pkg::CS_CRANK_REST);
   endfunction : in_crank

   // Qualifier window; only the configurable alarm functions are gated
   function automatic logic qual_ok(input cid_pkg::cid_incfg_s c, input cid_pkg::cid_ctl_e s);
      logic cw;
      logic rw;
      cw = in_crank(s);
      rw = (s == cid_pkg::CS_RUN);
      case (c.qual)
         cid_pkg::Q_GLOBAL: qual_ok = 1'b1;
         cid_pkg::Q_CRANK:  qual_ok = cw;
         cid_pkg::Q_RUN:    qual_ok = rw;
         default:           qual_ok = cw | rw;
      endcase
      if (!(c.func inside {cid_pkg::FN_CFG_WARN1, cid_pkg::FN_CFG_WARN2,
                           cid_pkg::FN_CFG_FAIL1, cid_pkg::FN_CFG_FAIL2}))
         qual_ok = 1'b1;
   endfunction : qual_ok

   logic [N-1:0]             s1_q;
   logic [N-1:0]             s2_q;
   logic [N-1:0]             s3_q;
   logic [N-1:0]             deb_q;
   logic [N-1:0]             deb_prev_q;
   logic [15:0]              cnt_q [N];
   logic [N-1:0]             act;
   cid_pkg::cid_incfg_s      cfg_q [N];
   logic                     vreg_en_q;
   logic [cid_pkg::IRQ_W-1:0] stat_q;
   logic [cid_pkg::IRQ_W-1:0] stat_d;
   logic [cid_pkg::IRQ_W-1:0] mask_q;
   logic [cid_pkg::IRQ_W-1:0] mask_d;
   logic [cid_pkg::IRQ_W-1:0] ev;
   logic [31:0]              fa;
   logic                     ss_q;
   cid_pkg::cid_out_s        out_d;
   logic [7:0]               addr_q;
   logic                     wr_pend_q;
   logic                     rd_pend_q;
   logic [31:0]              rd_val;
   logic                     take;
   logic                     wr_en;

   // Input synchroniser; first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= din_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Debounce: level must stay steady for DEB_CYCLES before it is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deb_q      <= '0;
         deb_prev_q <= '0;
         for (int i = 0; i < N; i++) cnt_q[i] <= 16'h0000;
      end else begin
         deb_prev_q <= deb_q;
         for (int i = 0; i < N; i++) begin
            if (s2_q[i] != s3_q[i] || s3_q[i] == deb_q[i]) begin
               cnt_q[i] <= 16'h0000;
            end else if (cnt_q[i] == DEB_M1) begin
               deb_q[i] <= s3_q[i];
               cnt_q[i] <= 16'h0000;
            end else begin
               cnt_q[i] <= cnt_q[i] + 16'h0001;
            end
         end
      end
   end

   // Function activity gathered from all inputs
   always_comb begin
      fa = '0;
      for (int i = 0; i < N; i++) begin
         act[i] = deb_q[i] ^ cfg_q[i].inv;
         if (act[i] && qual_ok(cfg_q[i], ctl_state))
            fa[cfg_q[i].func] = 1'b1;
      end
      fa[cid_pkg::FN_NONE] = 1'b0;
   end

   always_comb begin
      out_d.fail[cid_pkg::FL_AIR]    = fa[cid_pkg::FN_LOW_AIR];
      out_d.fail[cid_pkg::FL_HYD]    = fa[cid_pkg::FN_LOW_HYD];
      out_d.fail[cid_pkg::FL_OIL]    = fa[cid_pkg::FN_LOW_OIL];
      out_d.fail[cid_pkg::FL_COOL]   = fa[cid_pkg::FN_LOW_COOL];
      out_d.fail[cid_pkg::FL_SUPPLY] = fa[cid_pkg::FN_SUPPLY_LOAD] && in_crank(ctl_state);
      out_d.fail[cid_pkg::FL_AUX]    = fa[cid_pkg::FN_AUX_FAIL];
      out_d.fail[cid_pkg::FL_CFG1]   = fa[cid_pkg::FN_CFG_FAIL1];
      out_d.fail[cid_pkg::FL_CFG2]   = fa[cid_pkg::FN_CFG_FAIL2];
      out_d.warn[cid_pkg::WN_AUX]    = fa[cid_pkg::FN_AUX_WARN];
      out_d.warn[cid_pkg::WN_CHG1]   = fa[cid_pkg::FN_CHG1];
      out_d.warn[cid_pkg::WN_CHG2]   = fa[cid_pkg::FN_CHG2];
      out_d.warn[cid_pkg::WN_FUEL]   = fa[cid_pkg::FN_HI_FUEL];
      out_d.warn[cid_pkg::WN_CFG1]   = fa[cid_pkg::FN_CFG_WARN1];
      out_d.warn[cid_pkg::WN_CFG2]   = fa[cid_pkg::FN_CFG_WARN2];
      out_d.msg_show    = {fa[cid_pkg::FN_CFG_FAIL2], fa[cid_pkg::FN_CFG_FAIL1],
                           fa[cid_pkg::FN_CFG_WARN2], fa[cid_pkg::FN_CFG_WARN1]};
      out_d.supply_lamp = fa[cid_pkg::FN_SUPPLY_LOAD] && (ctl_state == cid_pkg::CS_RUN);
      out_d.buzzer_mute = fa[cid_pkg::FN_SILENCE];
      out_d.volt_sel    = {fa[cid_pkg::FN_VSEL2], fa[cid_pkg::FN_VSEL1]};
      out_d.idle_show   = fa[cid_pkg::FN_IDLE];
      out_d.under_inhibit = fa[cid_pkg::FN_IDLE];
      out_d.vreg_off    = fa[cid_pkg::FN_IDLE] && vreg_en_q;
      out_d.start_req   = fa[cid_pkg::FN_START_STOP] && !ss_q &&
                          (ctl_state == cid_pkg::CS_AUTO);
      out_d.stop_req    = !fa[cid_pkg::FN_START_STOP] && ss_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fn_out <= '0;
         ss_q   <= 1'b0;
      end else begin
         fn_out <= out_d;
         ss_q   <= fa[cid_pkg::FN_START_STOP];
      end
   end

   // Bus slave: writes without wait, reads with one wait state
   assign take  = hsel && htrans[1] && hready;
   assign wr_en = wr_pend_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q    <= 8'h00;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         if (take) addr_q <= haddr[7:0];
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         hreadyout <= !(take && !hwrite);
         hresp     <= 1'b0;
         if (rd_pend_q) hrdata <= rd_val;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      for (int i = 0; i < N; i++)
         if (addr_q == cid_pkg::INCFG0_OFS + 8'(4 * i)) rd_val = {24'h00_0000, cfg_q[i]};
      case (addr_q)
         cid_pkg::CTRL_OFS:     rd_val[cid_pkg::CTRL_VREG_BIT] = vreg_en_q;
         cid_pkg::LEVEL_OFS:    rd_val = {16'h0000, act, deb_q};
         cid_pkg::OUTSTAT_OFS:  rd_val = {5'h00, fn_out};
         cid_pkg::IRQ_STAT_OFS: rd_val = {27'h000_0000, stat_q};
         cid_pkg::IRQ_MASK_OFS: rd_val = {27'h000_0000, mask_q};
         default: ;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < N; i++) cfg_q[i] <= cid_pkg::cid_incfg_s'(cid_pkg::INCFG_RST);
         vreg_en_q <= cid_pkg::CTRL_RST;
      end else if (wr_en) begin
         for (int i = 0; i < N; i++)
            if (addr_q == cid_pkg::INCFG0_OFS + 8'(4 * i))
               cfg_q[i] <= cid_pkg::cid_incfg_s'(hwdata[7:0]);
         if (addr_q == cid_pkg::CTRL_OFS) vreg_en_q <= hwdata[cid_pkg::CTRL_VREG_BIT];
      end
   end

   // Interrupt events; a new event wins over a same-cycle clear
   always_comb begin
      ev = '0;
      ev[cid_pkg::IRQ_FAIL]  = |(out_d.fail & ~fn_out.fail);
      ev[cid_pkg::IRQ_WARN]  = |(out_d.warn & ~fn_out.warn);
      ev[cid_pkg::IRQ_START] = out_d.start_req;
      ev[cid_pkg::IRQ_STOP]  = out_d.stop_req;
      ev[cid_pkg::IRQ_CHG]   = |(deb_q ^ deb_prev_q);
      stat_d = stat_q;
      mask_d = mask_q;
      if (wr_en && addr_q == cid_pkg::IRQ_STAT_OFS) stat_d = stat_q & ~hwdata[cid_pkg::IRQ_W-1:0];
      if (wr_en && addr_q == cid_pkg::IRQ_MASK_OFS) mask_d = hwdata[cid_pkg::IRQ_W-1:0];
      stat_d = stat_d | ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q <= '0;
         mask_q <= cid_pkg::MASK_RST;
         irq    <= 1'b0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq    <= |(stat_d & mask_d);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   cfg_write_a: assert property (
      wr_en && addr_q == cid_pkg::INCFG0_OFS |=> cfg_q[0] == $past(hwdata[7:0]))
      else $error("input config write not taken");

   fail_map_a: assert property (
      fn_out.fail[3:0] == $past({fa[cid_pkg::FN_LOW_COOL], fa[cid_pkg::FN_LOW_OIL],
                                 fa[cid_pkg::FN_LOW_HYD], fa[cid_pkg::FN_LOW_AIR]}))
      else $error("engine failure mapping wrong");

   supply_abort_a: assert property (
      fa[cid_pkg::FN_SUPPLY_LOAD] && in_crank(ctl_state) |=> fn_out.fail[cid_pkg::FL_SUPPLY])
      else $error("load supply failure missing while starting");

   supply_lamp_a: assert property (
      fa[cid_pkg::FN_SUPPLY_LOAD] && ctl_state == cid_pkg::CS_RUN
      |=> fn_out.supply_lamp && !fn_out.fail[cid_pkg::FL_SUPPLY])
      else $error("load supply lamp wrong in run");

   buzzer_mute_a: assert property (
      fn_out.buzzer_mute == $past(fa[cid_pkg::FN_SILENCE]))
      else $error("buzzer mute does not follow input");

   volt_select_a: assert property (
      fn_out.volt_sel == $past({fa[cid_pkg::FN_VSEL2], fa[cid_pkg::FN_VSEL1]}))
      else $error("voltage select wrong");

   idle_inhibit_a: assert property (
      fa[cid_pkg::FN_IDLE] |=> fn_out.under_inhibit && fn_out.idle_show)
      else $error("idle not applied");

   vreg_drive_a: assert property (
      fn_out.vreg_off == $past(fa[cid_pkg::FN_IDLE] && vreg_en_q))
      else $error("regulator output wrong");

   start_pulse_a: assert property (
      $rose(fa[cid_pkg::FN_START_STOP]) && ctl_state == cid_pkg::CS_AUTO
      |=> fn_out.start_req ##1 !fn_out.start_req)
      else $error("start request not a single pulse");

   stop_pulse_a: assert property (
      $fell(fa[cid_pkg::FN_START_STOP]) |=> fn_out.stop_req)
      else $error("stop request missing");

   aux_fail_a: assert property (
      fa[cid_pkg::FN_AUX_FAIL] |=> fn_out.fail[cid_pkg::FL_AUX])
      else $error("auxiliary failure missing");

   warn_map_a: assert property (
      fn_out.warn[3:0] == $past({fa[cid_pkg::FN_HI_FUEL], fa[cid_pkg::FN_CHG2],
                                 fa[cid_pkg::FN_CHG1], fa[cid_pkg::FN_AUX_WARN]}))
      else $error("warning mapping wrong");

   qual_run_a: assert property (
      cfg_q[N-1].func == cid_pkg::FN_CFG_WARN1 && cfg_q[N-1].qual == cid_pkg::Q_RUN && act[N-1]
      |-> fa[cid_pkg::FN_CFG_WARN1] || ctl_state != cid_pkg::CS_RUN)
      else $error("run qualifier blocked input in run");

   debounce_a: assert property (
      deb_q[0] != $past(deb_q[0]) |-> $past(cnt_q[0]) == DEB_M1)
      else $error("debounced level changed early");

   aux_warn_a: assert property (
      fa[cid_pkg::FN_AUX_WARN] |=> fn_out.warn[cid_pkg::WN_AUX])
      else $error("auxiliary warning missing");

   idle_show_a: assert property (
      fn_out.idle_show == $past(fa[cid_pkg::FN_IDLE]))
      else $error("idle indication does not follow input");

   cfg_fail_a: assert property (
      fa[cid_pkg::FN_CFG_FAIL1] |=> fn_out.fail[cid_pkg::FL_CFG1] && fn_out.msg_show[2])
      else $error("configurable failure or its message missing");

   msg_show_a: assert property (
      fn_out.msg_show == $past({fa[cid_pkg::FN_CFG_FAIL2], fa[cid_pkg::FN_CFG_FAIL1],
                                fa[cid_pkg::FN_CFG_WARN2], fa[cid_pkg::FN_CFG_WARN1]}))
      else $error("message display mapping wrong");

   supply_quiet_a: assert property (
      !in_crank(ctl_state) && ctl_state != cid_pkg::CS_RUN
      |=> !fn_out.fail[cid_pkg::FL_SUPPLY] && !fn_out.supply_lamp)
      else $error("load supply active outside start and run");

   lamp_run_only_a: assert property (
      fn_out.supply_lamp |-> $past(ctl_state == cid_pkg::CS_RUN))
      else $error("load supply lamp lit outside run");

   start_auto_a: assert property (
      fn_out.start_req |-> $past(ctl_state == cid_pkg::CS_AUTO))
      else $error("start request outside automatic state");

   qual_crank_a: assert property (
      cfg_q[N-1].func == cid_pkg::FN_CFG_WARN1 && cfg_q[N-1].qual == cid_pkg::Q_CRANK && act[N-1]
      && in_crank(ctl_state) |-> fa[cid_pkg::FN_CFG_WARN1])
      else $error("crank qualifier blocked input while starting");

   // Bus timing and interrupt status
   read_wait_a: assert property (
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   write_nowait_a: assert property (
      take && hwrite |=> hreadyout)
      else $error("write stalled");

   fail_event_a: assert property (
      ev[cid_pkg::IRQ_FAIL] |=> stat_q[cid_pkg::IRQ_FAIL])
      else $error("new failure not recorded in status");

   chg_event_a: assert property (
      deb_q != $past(deb_q) |=> stat_q[cid_pkg::IRQ_CHG])
      else $error("input change not recorded in status");

   irq_level_a: assert property (
      irq == |(stat_q & mask_q))
      else $error("interrupt level wrong");

   start_seen_c: cover property (fn_out.start_req ##[1:100] fn_out.stop_req);
   abort_seen_c: cover property (fn_out.fail[cid_pkg::FL_SUPPLY]);
   irq_seen_c:   cover property ($rose(irq));
   qual_gate_c:  cover property (fa[cid_pkg::FN_CFG_FAIL2] && ctl_state == cid_pkg::CS_RUN);
   vreg_off_c:   cover property (fn_out.vreg_off);

endmodule : cid_top

// ### tb/cid_switches.sv
// Model of the engine-side contacts and sensor switches feeding the inputs
`timescale 1ns/1ns
module cid_switches (
   input  wire logic       hclk,
   input  wire logic [7:0] contacts,
   output logic [7:0]      din_raw
);
   logic [7:0] settled_q;
   logic [7:0] moved_q;
   int         chatter_q;
   initial begin
      settled_q = 8'h00;
      moved_q   = 8'h00;
      chatter_q = 0;
      din_raw   = 8'h00;
   end
   // A moved contact bounces for three cycles before it holds, as real switches do
   always @(posedge hclk) begin
      if (contacts !== settled_q) begin
         moved_q   <= contacts ^ settled_q;
         settled_q <= contacts;
         chatter_q <= 3;
      end else if (chatter_q > 0) begin
         chatter_q <= chatter_q - 1;
      end
      din_raw <= (chatter_q % 2 == 1) ? (settled_q ^ moved_q) : settled_q;
   end
endmodule : cid_switches

// ### tb/tb_top.sv
// Self-checking bench for the configurable input dispatcher
`timescale 1ns/1ns
module tb_top;
   localparam int DEB = 4;
   logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [7:0]        contacts, din_raw;
   cid_pkg::cid_ctl_e ctl_state;
   cid_pkg::cid_out_s fn_out;
   int                errors, n_compared, n_start, n_stop;

   cid_top #(.DEB_CYCLES(DEB)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .din_raw(din_raw),
      .ctl_state(ctl_state), .fn_out(fn_out), .irq(irq));
   cid_switches i_sw (.hclk(hclk), .contacts(contacts), .din_raw(din_raw));

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // One-cycle request pulses are counted so their number and width show up
   always @(posedge hclk) begin
      if (fn_out.start_req === 1'b1) n_start <= n_start + 1;
      if (fn_out.stop_req === 1'b1) n_stop <= n_stop + 1;
   end

   task automatic end_of_test;
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_ready(output logic [31:0] data);
      logic ok;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(negedge hclk);
         ok = (hreadyout === 1'b1);
         data = hrdata;
         if (ok) check(32'(hresp), 32'h0000_0000);
         @(posedge hclk);
      end
      if (!ok) begin
         check(32'h0000_0000, 32'h0000_0001);
         end_of_test();
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h00_0000, a};
      wait_ready(rd);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready(rd);
   endtask : bus

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rchk

   task automatic cfg(input int i, input logic [4:0] fn, input logic [1:0] q, input logic inv);
      bus(1'b1, cid_pkg::INCFG0_OFS + 8'(4 * i), {24'h00_0000, inv, q, fn});
   endtask : cfg

   task automatic apply(input logic [7:0] v);
      @(posedge hclk);
      contacts <= v;
      repeat (DEB + 16) @(posedge hclk);
      @(negedge hclk);
   endtask : apply

   task automatic setst(input cid_pkg::cid_ctl_e s);
      @(posedge hclk);
      ctl_state <= s;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask : setst

   task automatic t_reset;
      check(32'(fn_out), 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      rchk(cid_pkg::INCFG0_OFS + 8'h1C, 32'h0000_0000);
      rchk(cid_pkg::CTRL_OFS, 32'h0000_0000);
      rchk(cid_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      rchk(8'h40, 32'h0000_0000);
      bus(1'b1, cid_pkg::INCFG0_OFS + 8'h0C, 32'hFFFF_FFFF);
      rchk(cid_pkg::INCFG0_OFS + 8'h0C, 32'h0000_00FF);
      cfg(3, 5'h00, 2'd0, 1'b0);
   endtask : t_reset

   task automatic t_alarms;
      logic [4:0] fn [9] = '{5'd1, 5'd2, 5'd3, 5'd6, 5'd11, 5'd12, 5'd13, 5'd14, 5'd15};
      int         pos [9] = '{6, 7, 8, 9, 11, 0, 1, 2, 3};
      cid_pkg::cid_ctl_e st [4] = '{cid_pkg::CS_OFF, cid_pkg::CS_AUTO, cid_pkg::CS_CRANKING, cid_pkg::CS_RUN};
      for (int s = 0; s < 4; s++) begin
         setst(st[s]);
         for (int k = 0; k < 9; k++) begin
            cfg(0, fn[k], 2'd0, 1'b0);
            apply(8'h01);
            check(32'({fn_out.fail, fn_out.warn}), 32'h0000_0001 << pos[k]);
            apply(8'h00);
            check(32'({fn_out.fail, fn_out.warn}), 32'h0000_0000);
         end
      end
      cfg(0, 5'd1, 2'd0, 1'b1);
      apply(8'h00);
      check(32'(fn_out.fail), 32'h0000_0001);
      cfg(0, 5'd3, 2'd0, 1'b0);
      @(posedge hclk);
      contacts <= 8'h01;
      apply(8'h00);
      check(32'(fn_out.fail), 32'h0000_0000);
      cfg(1, 5'd0, 2'd0, 1'b0);
      apply(8'h02);
      check(32'(fn_out), 32'h0000_0000);
      rchk(cid_pkg::LEVEL_OFS, 32'h0000_0202);
      apply(8'h00);
   endtask : t_alarms

   task automatic t_supply;
      cid_pkg::cid_ctl_e st [5] = '{cid_pkg::CS_DELAY_START, cid_pkg::CS_CRANKING, cid_pkg::CS_CRANK_REST,
                                    cid_pkg::CS_RUN, cid_pkg::CS_AUTO};
      logic [1:0] exp [5] = '{2'b10, 2'b10, 2'b10, 2'b01, 2'b00};
      cfg(0, 5'd4, 2'd0, 1'b0);
      apply(8'h01);
      for (int s = 0; s < 5; s++) begin
         setst(st[s]);
         check(32'({fn_out.fail[cid_pkg::FL_SUPPLY], fn_out.supply_lamp}), 32'(exp[s]));
      end
      apply(8'h00);
   endtask : t_supply

   task automatic t_panel;
      cfg(2, 5'd5, 2'd0, 1'b0);
      cfg(3, 5'd7, 2'd0, 1'b0);
      cfg(4, 5'd8, 2'd0, 1'b0);
      cfg(5, 5'd9, 2'd0, 1'b0);
      bus(1'b1, cid_pkg::CTRL_OFS, 32'h0000_0001);
      apply(8'h0C);
      check(32'({fn_out.buzzer_mute, fn_out.volt_sel, fn_out.idle_show, fn_out.under_inhibit,
                 fn_out.vreg_off}), 32'h0000_0028);
      apply(8'h3C);
      check(32'({fn_out.buzzer_mute, fn_out.volt_sel, fn_out.idle_show, fn_out.under_inhibit,
                 fn_out.vreg_off}), 32'h0000_003F);
      bus(1'b1, cid_pkg::CTRL_OFS, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      check(32'(fn_out.vreg_off), 32'h0000_0000);
      apply(8'h00);
      check(32'(fn_out), 32'h0000_0000);
   endtask : t_panel

   task automatic t_start_stop;
      int s0, p0;
      cfg(6, 5'd10, 2'd0, 1'b0);
      setst(cid_pkg::CS_AUTO);
      s0 = n_start;
      p0 = n_stop;
      apply(8'h40);
      check(32'(n_start - s0), 32'h0000_0001);
      setst(cid_pkg::CS_RUN);
      apply(8'h00);
      check(32'(n_stop - p0), 32'h0000_0001);
      apply(8'h40);
      check(32'(n_start - s0), 32'h0000_0001);
      apply(8'h00);
   endtask : t_start_stop

   task automatic t_qual;
      cid_pkg::cid_ctl_e st [4] = '{cid_pkg::CS_AUTO, cid_pkg::CS_DELAY_START, cid_pkg::CS_CRANK_REST,
                                    cid_pkg::CS_RUN};
      logic [31:0] pm [4] = '{32'h0000_0101, 32'h0000_0202, 32'h0001_0004, 32'h0002_0008};
      logic        act;
      for (int f = 0; f < 4; f++) begin
         for (int q = 0; q < 4; q++) begin
            cfg(7, 5'(16 + f), 2'(q), 1'b0);
            apply(8'h80);
            for (int s = 0; s < 4; s++) begin
               setst(st[s]);
               act = (q == 0) || (q[0] && (s == 1 || s == 2)) || (q[1] && s == 3);
               check(32'({fn_out.fail, fn_out.warn, fn_out.msg_show}), act ? pm[f] : 32'h0000_0000);
            end
            apply(8'h00);
         end
      end
   endtask : t_qual

   task automatic t_irq;
      cfg(0, 5'd1, 2'd0, 1'b0);
      bus(1'b1, cid_pkg::IRQ_MASK_OFS, 32'h0000_0001);
      bus(1'b1, cid_pkg::IRQ_STAT_OFS, 32'h0000_001F);
      apply(8'h01);
      check(32'(irq), 32'h0000_0001);
      bus(1'b1, cid_pkg::IRQ_STAT_OFS, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      check(32'(irq), 32'h0000_0000);
      bus(1'b1, cid_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      apply(8'h00);
      apply(8'h01);
      check(32'(irq), 32'h0000_0000);
      bus(1'b0, cid_pkg::IRQ_STAT_OFS, 32'h0000_0000);
      check(32'(rd[cid_pkg::IRQ_FAIL]), 32'h0000_0001);
      apply(8'h00);
   endtask : t_irq

   initial begin
      hresetn   = 1'b0;
      hsel      = 1'b0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      haddr     = 32'h0000_0000;
      hwdata    = 32'h0000_0000;
      hsize     = 3'b010;
      contacts  = 8'h00;
      ctl_state = cid_pkg::CS_OFF;
      errors    = 0;
      n_compared = 0;
      n_start   = 0;
      n_stop    = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      t_reset();
      t_alarms();
      t_supply();
      t_panel();
      t_start_stop();
      t_qual();
      t_irq();
      end_of_test();
   end

   initial begin
      repeat (90000) @(posedge hclk);
      check(32'h0000_0000, 32'h0000_0001);
      end_of_test();
   end
endmodule : tb_top
